// *** verif/converter_model.sv ***
// Behavioural converter that answers conversion requests
`timescale 1ns/1ns
module converter_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        meas_start,
  input  wire logic [31:0] value,
  input  wire logic        sig,
  output logic             meas_done,
  output logic [31:0]      meas_value,
  output logic             meas_signal
);
  logic [2:0] cnt_r;  // Cycles left before the answer
  logic       busy_r; // Conversion in flight
  logic       slow_r; // Alternates prompt and slow answers
  // One answer per request; stale data toggles so it never looks valid
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      {cnt_r, busy_r, slow_r, meas_done, meas_signal} <= 7'h00;
      meas_value <= 32'h0;
    end else begin
      meas_done   <= 1'b0;
      meas_value  <= ~meas_value;
      meas_signal <= ~meas_signal;
      if (meas_start) begin
        busy_r <= 1'b1;
        cnt_r  <= slow_r ? 3'h4 : 3'h0;
        slow_r <= ~slow_r;
      end else if (busy_r && cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end else if (busy_r) begin
        // Answer carries the reading and signal flag
        {busy_r, meas_done, meas_value, meas_signal} <= {2'h1, value, sig};
      end
    end
  end
endmodule

// *** verif/meter_trigger_control_tb.sv ***
// Self-checking bench for the meter trigger controller
`timescale 1ns/1ns
module meter_trigger_control_tb;
  import meter_trigger_pkg::*;
  logic clock, reset, hsel, hwrite, hreadyout, hresp, meas_done, meas_signal, meas_start;
  logic meas_path, overload_display, sig;
  logic [1:0]  htrans;
  logic [2:0]  hsize, meas_range;
  logic [31:0] haddr, hwdata, hrdata, meas_value, val, rdat;
  int          num_errors, checks_done, i;
  typedef struct packed {logic [31:0] v; logic s; logic [31:0] e;} row_s;
  row_s        rows [5]; // Converter answer beside the stored reading
  always #25 clock = ~clock;
  meter_trigger_control meter_trigger_control_inst (.clock, .reset, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .meas_done,
    .meas_value, .meas_signal, .meas_start, .meas_path, .meas_range, .overload_display);
  converter_model converter_model_inst (.clock, .reset, .meas_start, .value(val), .sig,
    .meas_done, .meas_value, .meas_signal);
  // ********************************
  // Bus tasks, checks and closing
  // ********************************
  task end_sim;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wait_rdy;
    int n;
    for (n = 0; n < 50 && hreadyout !== 1'b1; n++) @(posedge clock);
    if (n == 50) begin
      num_errors++;
      end_sim;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    {hsel, hwrite, htrans, haddr} <= {4'hE, 24'h0, a};
    @(posedge clock); wait_rdy;
    {hwrite, htrans, hwdata} <= {3'h0, d};
    @(posedge clock); wait_rdy;
  endtask
  task cmd(input logic [3:0] c);
    wr(ADDR_CMD, {28'h0, c});
  endtask
  // Idle cycle first: a read never follows a command directly
  task rd(input logic [7:0] a);
    @(posedge clock);
    {hsel, hwrite, htrans, haddr} <= {4'h A, 24'h0, a};
    @(posedge clock); wait_rdy;
    htrans <= 2'h0;
    @(posedge clock); wait_rdy;
    rdat = hrdata;
  endtask
  task poll(input logic [31:0] m, input logic [31:0] w);
    int n;
    for (n = 0; n < 300; n++) begin
      rd(ADDR_STATUS);
      if ((rdat & m) == w) break;
    end
    if (n == 300) begin
      num_errors++;
      end_sim;
    end
  endtask
  initial begin
    {clock, reset, hsel, hwrite, htrans, hsize, haddr, hwdata} = {4'h4, 2'h0, 3'h2, 64'h0};
    {val, sig} = {32'h1234, 1'b1};
    rows = '{'{32'h0000_C350, 1'b1, 32'h0000_C350}, '{32'h0000_0010, 1'b1, 32'h0000_0010},
      '{32'h0001_D4C1, 1'b1, SENT_POS_OVL}, '{32'hFFFE_2B3F, 1'b1, SENT_NEG_OVL},
      '{32'h0000_C350, 1'b0, READING_ZERO}};
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    rd(ADDR_CONT); chk(rdat, 32'h1);
    rd(ADDR_ACV_RANGE); chk(rdat, {27'h0, RANGE_RESET});
    poll(32'h20, 32'h20); rd(ADDR_MEM); chk(rdat, 32'h1234);
    // Duty configure undoes source and math, keeps the manual voltage range
    wr(ADDR_CONT, 32'h0); wr(ADDR_ACV_RANGE, 32'h2); wr(ADDR_FUNC, 32'h1);
    wr(ADDR_MATH_EN, 32'hF); wr(ADDR_TRIG_SRC, 32'h1); cmd(CMD_CONF_DUTY);
    rd(ADDR_MATH_EN); chk(rdat, 32'h0);
    rd(ADDR_TRIG_SRC); chk(rdat, 32'h0);
    rd(ADDR_FUNC); chk(rdat & 32'h3, {30'h0, FUNC_DUTY});
    rd(ADDR_STATUS); chk(rdat & 32'h3, 32'h0);
    chk({29'h0, meas_range}, 32'h2);
    // Ordinary triggered readings, then fetch
    for (i = 0; i < 5; i++) begin
      {val, sig} <= {rows[i].v, rows[i].s};
      cmd(CMD_INIT); poll(32'h23, 32'h20);
      rd(ADDR_MEM); chk(rdat, rows[i].e);
      chk({31'h0, overload_display}, {31'h0, rows[i].e == SENT_POS_OVL || rows[i].e == SENT_NEG_OVL});
      cmd(CMD_FETCH); poll(32'h40, 32'h40);
      rd(ADDR_OUT_BUF); chk(rdat, rows[i].e);
    end
    // Read query from free run, then bus trigger, abort and measure
    {val, sig} <= {32'h77, 1'b1}; wr(ADDR_CONT, 32'h1); cmd(CMD_READ); poll(32'h60, 32'h60);
    rd(ADDR_CONT); chk(rdat, 32'h0);
    rd(ADDR_OUT_BUF); chk(rdat, 32'h77);
    wr(ADDR_TRIG_SRC, 32'h1); cmd(CMD_INIT);
    rd(ADDR_STATUS); chk(rdat & 32'h23, 32'h1);
    cmd(CMD_TRG); poll(32'h23, 32'h20);
    rd(ADDR_MEM); chk(rdat, 32'h77);
    cmd(CMD_INIT); cmd(CMD_ABORT);
    rd(ADDR_STATUS); chk(rdat & 32'h3, 32'h0);
    val <= 32'h55; cmd(CMD_MEAS); poll(32'h40, 32'h40);
    rd(ADDR_OUT_BUF); chk(rdat, 32'h55);
    // Autorange climbs; a fetch while settling gets the ranging word
    {val, sig} <= {32'h0001_D4C1, 1'b1}; wr(ADDR_ACV_RANGE, 32'h10); cmd(CMD_CONF_DUTY);
    cmd(CMD_INIT); poll(32'h80, 32'h80); cmd(CMD_FETCH);
    rd(ADDR_OUT_BUF); chk(rdat, SENT_RANGING);
    poll(32'h23, 32'h20); rd(ADDR_MEM); chk(rdat, SENT_POS_OVL);
    chk({29'h0, meas_range}, {29'h0, RANGE_TOP});
    rd(8'h30); chk(rdat, 32'h0);
    rd(ADDR_CMD); chk(rdat, 32'h0);
    end_sim;
  end
endmodule

// *** verif/meter_trigger_properties.sv ***
// Port-level assertions for the meter trigger controller
`timescale 1ns/1ns
module meter_trigger_properties
  import meter_trigger_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        meas_done,
  input wire logic        meas_start,
  input wire logic [2:0]  meas_range,
  input wire logic        overload_display
);
  // ********************************
  // Bus and converter relations
  // ********************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Accepted read address phase
  sequence rd_req;
    hsel && htrans[1] && !hwrite && hready;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_start_pulse: assert property (meas_start |=> !meas_start) else $error("start too long");
  a_range_limit: assert property (meas_range <= RANGE_TOP) else $error("range out of set");
  a_ovl_cause: assert property ($changed(overload_display) |-> $past(meas_done))
    else $error("overload flag moved without a reading");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite && hready))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd_req ##0 haddr[7:0] > ADDR_MEM |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_cmd_zero: assert property (rd_req ##0 haddr[7:0] == ADDR_CMD |=> hrdata == 32'h0)
    else $error("command word read not zero");
  a_cont_bool: assert property (rd_req ##0 haddr[7:0] == ADDR_CONT |=> hrdata[31:1] == 31'h0)
    else $error("continuous readback not boolean");
endmodule
bind meter_trigger_control meter_trigger_properties chk_inst (.clock, .reset, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .meas_done, .meas_start, .meas_range,
  .overload_display);

// *** verilog/meter_trigger_control.sv ***
// Command-driven trigger, ranging and reading store of the meter
//
// What this block does
// R1 - Duty configure resets settings, selects duty function
// R2 - Duty configure never enters wait-for-trigger
// R3 - Duty configure sets immediate source, math off
// R4 - Range follows configured AC voltage or current
// R5 - No input signal gives zero reading
// R6 - Autorange down below 10%, up above 120%
// R7 - Manual range overload returns signed sentinel
// R8 - Query during range change returns ranging sentinel
// R9 - Initiate waits, then measures on trigger
// R10 - Initiate erases stored reading
// R11 - Initiate stores reading; fetch copies to output
// R12 - Abort returns trigger system to idle
// R13 - Continuous mode free-runs storing readings
// R14 - Continuous setting takes 0/1, reads back boolean
// R15 - Initiate or read forces continuous off
// R16 - Read waits, measures, fills memory and output
// R17 - Bus source waits for software trigger
// R18 - Measure query configures, measures, fills output
// R19 - Host allows fifteen second query timeout
// R20 - Host fixes range below twenty hertz
// R21 - Triggered measurement returns to idle afterwards
`timescale 1ns/1ns
module meter_trigger_control
  import meter_trigger_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Converter on the same clock
  input  wire logic        meas_done,
  input  wire logic [31:0] meas_value,
  input  wire logic        meas_signal,
  output logic             meas_start,
  output logic             meas_path,
  output logic [2:0]       meas_range,
  output logic             overload_display
);

  // ********************************
  // Declarations
  // ********************************
  trig_state_e state_r;        // Trigger system state
  trig_state_e state_nxt;
  logic        acc_wr_r;       // Write data phase pending
  logic [7:0]  addr_r;         // Captured byte address
  logic [31:0] hrdata_r;       // Read data for the data phase
  logic [31:0] rd_mux;         // Read value chosen at address phase
  logic        cont_r;         // Continuous mode
  logic        trig_src_r;     // Trigger source
  logic [3:0]  math_en_r;      // Calculation enables
  logic [4:0]  acv_range_r;    // AC voltage range setup
  logic [4:0]  aci_range_r;    // AC current range setup
  logic [1:0]  func_r;         // Active function
  logic        path_r;         // Path the duty function measures on
  logic [2:0]  cur_range_r;    // Range in use
  logic        dest_mem_r;     // Current measurement fills memory
  logic        dest_out_r;     // Current measurement fills output
  logic [31:0] mem_r;          // Reading memory
  logic        mem_valid_r;
  logic [31:0] out_r;          // Output buffer
  logic        out_valid_r;
  logic        ranging_r;      // Autorange change in progress
  logic        start_nxt;      // Converter start for next cycle
  logic        settle_busy;    // Range settling still running
  logic        settle_load;
  logic        below_floor;
  logic        above_ceiling;
  logic        addr_go;        // Address phase accepted
  logic        wr_go;          // Write data phase now
  logic        cmd_go;         // Command register written
  logic [3:0]  cmd;
  logic        sel_auto;       // Autorange of the selected path
  logic [2:0]  sel_idx;        // Range index of the selected path
  logic        negative;
  logic [31:0] magnitude;
  logic        step_up;
  logic        step_down;
  logic        change;
  logic        store;          // Finished reading to be kept
  logic [31:0] result;         // Reading or sentinel

  // ********************************
  // Bus decode
  // ********************************
  assign addr_go = hsel & htrans[1] & hready;
  assign wr_go   = acc_wr_r;
  assign cmd_go  = wr_go & (addr_r == ADDR_CMD);
  assign cmd     = hwdata[3:0];

  // Address phase capture; every transfer ends in zero wait states
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      acc_wr_r <= 1'b0;
      addr_r   <= 8'h00;
    end else begin
      acc_wr_r <= addr_go & hwrite;
      addr_r   <= haddr[7:0];
    end
  end

  // Read mux; unmapped offsets read as zero with an OKAY answer
  always_comb begin
    unique case (haddr[7:0])
      ADDR_STATUS:    rd_mux = {24'h0, ranging_r, out_valid_r, mem_valid_r,
                                cont_r, 2'b00, state_r};
      ADDR_CONT:      rd_mux = {31'h0, cont_r};  // R14
      ADDR_TRIG_SRC:  rd_mux = {31'h0, trig_src_r};
      ADDR_MATH_EN:   rd_mux = {28'h0, math_en_r};
      ADDR_ACV_RANGE: rd_mux = {27'h0, acv_range_r};
      ADDR_ACI_RANGE: rd_mux = {27'h0, aci_range_r};
      ADDR_FUNC:      rd_mux = {29'h0, path_r, func_r};
      ADDR_OUT_BUF:   rd_mux = out_r;
      ADDR_MEM:       rd_mux = mem_r;
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data registered so the data phase sees a flop
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_go & ~hwrite) begin
      hrdata_r <= rd_mux;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ********************************
  // Configuration registers
  // ********************************
  // Continuous mode; initiate and read turn it off
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cont_r <= CONT_RESET;
    end else if (cmd_go && (cmd == CMD_INIT || cmd == CMD_READ)) begin
      cont_r <= 1'b0;                            // R15
    end else if (wr_go && addr_r == ADDR_CONT) begin
      cont_r <= hwdata[0];                       // R14
    end
  end

  // Trigger source and calculations; configure restores defaults
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      trig_src_r <= TRIG_IMMEDIATE;
      math_en_r  <= MATH_RESET;
    end else if (cmd_go && (cmd == CMD_CONF_DUTY || cmd == CMD_MEAS)) begin
      trig_src_r <= TRIG_IMMEDIATE;              // R1 R3
      math_en_r  <= MATH_RESET;                  // R3
    end else if (wr_go && addr_r == ADDR_TRIG_SRC) begin
      trig_src_r <= hwdata[0];
    end else if (wr_go && addr_r == ADDR_MATH_EN) begin
      math_en_r  <= hwdata[3:0];
    end
  end

  // AC range setups; the path is picked only by a function write
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      acv_range_r <= RANGE_RESET;
      aci_range_r <= RANGE_RESET;
    end else if (wr_go && addr_r == ADDR_ACV_RANGE) begin
      acv_range_r <= hwdata[4:0];
    end else if (wr_go && addr_r == ADDR_ACI_RANGE) begin
      aci_range_r <= hwdata[4:0];
    end
  end

  // Function and path; duty ratio inherits the last AC path
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      func_r <= FUNC_NONE;
      path_r <= PATH_VOLT;
    end else if (cmd_go && (cmd == CMD_CONF_DUTY || cmd == CMD_MEAS)) begin
      func_r <= FUNC_DUTY;                       // R1 R18
    end else if (wr_go && addr_r == ADDR_FUNC) begin
      func_r <= hwdata[1:0];
      if (hwdata[1:0] == FUNC_ACV) begin
        path_r <= PATH_VOLT;                     // R4
      end else if (hwdata[1:0] == FUNC_ACI) begin
        path_r <= PATH_CURR;                     // R4
      end
    end
  end

  // Autorange and range index of the selected path
  assign sel_auto = (path_r == PATH_CURR) ? aci_range_r[RANGE_AUTO_BIT]
                                          : acv_range_r[RANGE_AUTO_BIT]; // R4
  assign sel_idx  = (path_r == PATH_CURR) ? aci_range_r[2:0]
                                          : acv_range_r[2:0];            // R4

  // ********************************
  // Reading judgement
  // ********************************
  assign negative  = meas_value[31];
  assign magnitude = negative ? (~meas_value + 32'h0000_0001) : meas_value;

  range_judge u_judge (
    .magnitude     (magnitude),
    .below_floor   (below_floor),
    .above_ceiling (above_ceiling)
  );

  // A step is only possible while a neighbouring range exists
  assign step_up   = sel_auto & above_ceiling & (cur_range_r != RANGE_TOP);    // R6
  assign step_down = sel_auto & below_floor & (cur_range_r != RANGE_BOTTOM);   // R6
  assign change    = meas_signal & (step_up | step_down);

  // Reading or sentinel for a finished conversion
  always_comb begin
    if (!meas_signal) begin
      result = READING_ZERO;                     // R5
    end else if (above_ceiling) begin
      result = negative ? SENT_NEG_OVL : SENT_POS_OVL; // R7
    end else begin
      result = meas_value;
    end
  end

  // ********************************
  // Trigger state machine
  // ********************************
  always_comb begin
    state_nxt   = state_r;
    start_nxt   = 1'b0;
    settle_load = 1'b0;
    store       = 1'b0;
    if (cmd_go && cmd == CMD_ABORT) begin
      state_nxt = ST_IDLE;                       // R12
    end else if (cmd_go && cmd == CMD_MEAS) begin
      state_nxt = ST_MEAS;                       // R18
      start_nxt = 1'b1;
    end else if (cmd_go && (cmd == CMD_INIT || cmd == CMD_READ)) begin
      state_nxt = ST_WAIT;                       // R9 R16
    end else if (cmd_go && cmd == CMD_CONF_DUTY) begin
      state_nxt = ST_IDLE;                       // R2
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (cont_r) begin
            state_nxt = ST_MEAS;                 // R13
            start_nxt = 1'b1;
          end
        end
        ST_WAIT: begin
          // Bus source holds here until the software trigger
          if (trig_src_r == TRIG_IMMEDIATE || (cmd_go && cmd == CMD_TRG)) begin
            state_nxt = ST_MEAS;                 // R9 R17
            start_nxt = 1'b1;
          end
        end
        ST_MEAS: begin
          if (meas_done && change) begin
            state_nxt   = ST_SETTLE;             // R6
            settle_load = 1'b1;
          end else if (meas_done) begin
            state_nxt = ST_IDLE;                 // R21
            store     = 1'b1;
          end
        end
        ST_SETTLE: begin
          // Retake the reading once the new range has settled
          if (!settle_busy && !settle_load) begin
            state_nxt = ST_MEAS;
            start_nxt = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  settle_timer #(.WIDTH(8)) u_settle (
    .clock (clock),
    .reset (reset),
    .load  (settle_load),
    .count (SETTLE_CYCLES),
    .busy  (settle_busy)
  );

  // Destinations chosen by the command that started the run, or by continuous mode in idle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dest_mem_r <= 1'b0;
      dest_out_r <= 1'b0;
    end else if (cmd_go && cmd == CMD_INIT) begin
      dest_mem_r <= 1'b1;                        // R11
      dest_out_r <= 1'b0;
    end else if (cmd_go && cmd == CMD_READ) begin
      dest_mem_r <= 1'b1;                        // R16
      dest_out_r <= 1'b1;                        // R16
    end else if (cmd_go && cmd == CMD_MEAS) begin
      dest_mem_r <= 1'b0;
      dest_out_r <= 1'b1;                        // R18
    end else if (state_r == ST_IDLE && cont_r && !cmd_go) begin
      dest_mem_r <= 1'b1;                        // R13
      dest_out_r <= 1'b0;
    end
  end

  // Range in use: loaded from the path setup, stepped by autorange
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cur_range_r <= RANGE_BOTTOM;
      ranging_r   <= 1'b0;
    end else if (cmd_go && (cmd == CMD_CONF_DUTY || cmd == CMD_MEAS
                            || cmd == CMD_ABORT)) begin
      cur_range_r <= sel_idx;                    // R4
      ranging_r   <= 1'b0;
    end else if (settle_load) begin
      cur_range_r <= step_up ? cur_range_r + 3'h1 : cur_range_r - 3'h1; // R6
      ranging_r   <= 1'b1;                       // R8
    end else if (start_nxt) begin
      ranging_r   <= 1'b0;
    end
  end

  // ********************************
  // Reading memory and output buffer
  // ********************************
  // Memory: initiate erases, finished reading fills
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mem_r       <= READING_ZERO;
      mem_valid_r <= 1'b0;
    end else if (store && dest_mem_r) begin
      mem_r       <= result;                     // R11 R13 R16
      mem_valid_r <= 1'b1;
    end else if (cmd_go && cmd == CMD_INIT) begin
      mem_r       <= READING_ZERO;               // R10
      mem_valid_r <= 1'b0;                       // R10
    end
  end

  // Output buffer: valid until software reads it, a new word wins
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      out_r       <= READING_ZERO;
      out_valid_r <= 1'b0;
    end else if (cmd_go && cmd == CMD_FETCH && ranging_r) begin
      out_r       <= SENT_RANGING;               // R8
      out_valid_r <= 1'b1;
    end else if (cmd_go && cmd == CMD_FETCH) begin
      out_r       <= mem_r;                      // R11
      out_valid_r <= 1'b1;
    end else if (store && dest_out_r) begin
      out_r       <= result;                     // R16 R18
      out_valid_r <= 1'b1;
    end else if (addr_go && !hwrite && haddr[7:0] == ADDR_OUT_BUF) begin
      out_valid_r <= 1'b0;
    end
  end

  // ********************************
  // Converter and panel outputs
  // ********************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meas_start       <= 1'b0;
      meas_path        <= PATH_VOLT;
      meas_range       <= RANGE_BOTTOM;
      overload_display <= 1'b0;
    end else begin
      meas_start <= start_nxt;
      meas_path  <= path_r;
      meas_range <= settle_load ? meas_range : cur_range_r;
      if (store) begin
        overload_display <= meas_signal & above_ceiling;  // R7
      end
    end
  end

endmodule

// *** verilog/meter_trigger_pkg.sv ***
// Shared constants, codes and types of the meter trigger controller
package meter_trigger_pkg;

  // ********************************
  // Register map, byte offsets within the slave window
  // ********************************
  localparam logic [7:0] ADDR_CMD       = 8'h00; // Command strobe register
  localparam logic [7:0] ADDR_STATUS    = 8'h04; // Trigger state and flags
  localparam logic [7:0] ADDR_CONT      = 8'h08; // Continuous mode
  localparam logic [7:0] ADDR_TRIG_SRC  = 8'h0C; // Trigger source
  localparam logic [7:0] ADDR_MATH_EN   = 8'h10; // Calculation function enables
  localparam logic [7:0] ADDR_ACV_RANGE = 8'h14; // AC voltage range setup
  localparam logic [7:0] ADDR_ACI_RANGE = 8'h18; // AC current range setup
  localparam logic [7:0] ADDR_FUNC      = 8'h1C; // Active measurement function
  localparam logic [7:0] ADDR_OUT_BUF   = 8'h20; // Output buffer word
  localparam logic [7:0] ADDR_MEM       = 8'h24; // Reading memory word

  // ********************************
  // Command codes written to the command register
  // ********************************
  localparam logic [3:0] CMD_CONF_DUTY = 4'h1; // Configure duty ratio function
  localparam logic [3:0] CMD_INIT      = 4'h2; // Initiate
  localparam logic [3:0] CMD_ABORT     = 4'h3; // Abort to idle
  localparam logic [3:0] CMD_TRG       = 4'h4; // Software (bus) trigger
  localparam logic [3:0] CMD_READ      = 4'h5; // Read query
  localparam logic [3:0] CMD_FETCH     = 4'h6; // Fetch query
  localparam logic [3:0] CMD_MEAS      = 4'h7; // Measure query, duty ratio

  // ********************************
  // Field layouts and reset values
  // ********************************
  localparam int         RANGE_AUTO_BIT = 4;    // Autorange enable in range regs
  localparam logic [4:0] RANGE_RESET    = 5'h10; // Autorange, lowest range
  localparam logic [2:0] RANGE_TOP      = 3'h4; // Highest AC range index
  localparam logic [2:0] RANGE_BOTTOM   = 3'h0; // Lowest AC range index
  localparam logic       CONT_RESET     = 1'b1; // Continuous mode after reset
  localparam logic       TRIG_IMMEDIATE = 1'b0; // Trigger source codes
  localparam logic       TRIG_BUS       = 1'b1;
  localparam logic [3:0] MATH_RESET     = 4'h0; // All calculations off
  localparam logic       PATH_VOLT      = 1'b0; // Measuring path codes
  localparam logic       PATH_CURR      = 1'b1;

  // Measurement functions
  localparam logic [1:0] FUNC_NONE = 2'h0;
  localparam logic [1:0] FUNC_ACV  = 2'h1;
  localparam logic [1:0] FUNC_ACI  = 2'h2;
  localparam logic [1:0] FUNC_DUTY = 2'h3;

  // ********************************
  // Reading codes; sentinels stand in for +9.9E37, -9.9E37, +9.91E37
  // ********************************
  localparam logic [31:0] READING_ZERO = 32'h0000_0000;
  localparam logic [31:0] SENT_POS_OVL = 32'h7FFF_FFFF;
  localparam logic [31:0] SENT_NEG_OVL = 32'h8000_0001;
  localparam logic [31:0] SENT_RANGING = 32'h7FFF_FFFE;

  // Autorange thresholds in percent of full scale
  localparam logic [39:0] FULL_SCALE = 40'h00_0001_86A0; // Counts per range
  localparam logic [39:0] PCT_SCALE  = 40'h00_0000_0064; // 100 percent
  localparam logic [39:0] DOWN_PCT   = 40'h00_0000_000A; // 10 percent
  localparam logic [39:0] UP_PCT     = 40'h00_0000_0078; // 120 percent

  // ********************************
  // Timing
  // ********************************
  localparam int         CLOCK_PERIOD_NS = 50;   // 20 MHz clock
  localparam int         SETTLE_TIME_NS  = 1000; // Range relay settling, least
  localparam int         SETTLE_CYC_INT  =
    (SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [7:0] SETTLE_CYCLES   = SETTLE_CYC_INT[7:0];

  // Trigger system states
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_MEAS, ST_SETTLE} trig_state_e;

endpackage

// *** verilog/range_judge.sv ***
// Threshold comparator that judges a reading against its range
`timescale 1ns/1ns
module range_judge
  import meter_trigger_pkg::*;
(
  input  wire logic [31:0] magnitude,
  output logic             below_floor,
  output logic             above_ceiling
);

  // ********************************
  // Scaled comparison, widened so the percent products cannot wrap
  // ********************************
  logic [39:0] mag_scaled; // Reading times one hundred
  logic [39:0] floor_lvl;  // Ten percent level, same scale
  logic [39:0] ceil_lvl;   // One hundred twenty percent level

  assign mag_scaled    = {8'h00, magnitude} * PCT_SCALE;
  assign floor_lvl     = FULL_SCALE * DOWN_PCT;
  assign ceil_lvl      = FULL_SCALE * UP_PCT;
  assign below_floor   = mag_scaled < floor_lvl;  // R6
  assign above_ceiling = mag_scaled > ceil_lvl;   // R6

endmodule

// *** verilog/settle_timer.sv ***
// Down counter that holds off a measurement while a range settles
`timescale 1ns/1ns
module settle_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  output logic                  busy
);

  logic [WIDTH-1:0] remain_r; // Cycles still to wait

  // ********************************
  // Countdown; a fresh load restarts the wait
  // ********************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      remain_r <= '0;
    end else if (load) begin
      remain_r <= count;
    end else if (remain_r != '0) begin
      remain_r <= remain_r - 1'b1;
    end
  end

  assign busy = remain_r != '0;

endmodule
